// [dv/test_gpc_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "gpc_cfg.svh"
module test_gpc_port
  import gpc_pkg::*;
;
  // ==================================================
  // bench signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] ext = 16'h0;
  logic [15:0] af_out = 16'h0;
  logic [15:0] af_oe = 16'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, slew_sel, af_sel_lo, af_sel_hi;
  logic [15:0] pad_out, pad_oe, schmitt_en, pull_up_en, pull_dn_en;
  wire logic [15:0] pad_in;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // pad wire: driven level where enabled, outside level elsewhere
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);

  gpc_port #(.PORT_ID(2'h0)) u_gpc_port (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .schmitt_en(schmitt_en), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .slew_sel(slew_sel), .af_sel_lo(af_sel_lo), .af_sel_hi(af_sel_hi), .af_out(af_out), .af_oe(af_oe));

  // ==================================================
  // clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      summarize();
    end
  end

  // ==================================================
  // shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  function automatic logic [31:0] ad(input logic [9:0] o);
    return `GPC_BASE_A | {22'h0, o};
  endfunction : ad

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one write: address phase, then data phase
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
    @(posedge core_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge core_clk);
  endtask : wr

  // one read: data taken mid data phase
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
    @(posedge core_clk);
    hsel <= 1'b0; htrans <= 2'h0;
    @(negedge core_clk);
    d = hrdata;
    @(posedge core_clk);
  endtask : rd

  task automatic rchk(input string nm, input logic [9:0] o, input logic [31:0] e);
    logic [31:0] d;
    rd(ad(o), d);
    chk(nm, e, d);
  endtask : rchk

  // ==================================================
  // scenarios
  task automatic t_reset();
    rchk("mode", `GPC_OFF_MODE, 32'h2800_0000);
    rchk("otype", `GPC_OFF_OTYPE, 32'h0);
    @(negedge core_clk);
    chk("schmitt", 32'h0000_ffff, {16'h0, schmitt_en});
    chk("oe", 32'h0, {16'h0, pad_oe});
    @(posedge core_clk);
  endtask : t_reset

  task automatic t_out();
    ext <= 16'h000c;
    wr(ad(`GPC_OFF_MODE), 32'h2800_0035);
    wr(ad(`GPC_OFF_PULL), 32'h0000_0011);
    wr(ad(`GPC_OFF_OTYPE), 32'h0000_0002);
    wr(ad(`GPC_OFF_OCTL), 32'h0000_0007);
    @(negedge core_clk);
    chk("oe", 32'h1, {28'h0, pad_oe[3:0]});
    chk("out0", 32'h1, {31'h0, pad_out[0]});
    chk("schmitt", 32'h0000_fffb, {16'h0, schmitt_en});
    chk("pullup", 32'h0000_0001, {16'h0, pull_up_en});
    @(posedge core_clk);
    rchk("octl", `GPC_OFF_OCTL, 32'h0000_0007);
    rchk("istat", `GPC_OFF_ISTAT, 32'h0000_0009);
    wr(ad(`GPC_OFF_OCTL), 32'h0000_0004);
    @(negedge core_clk);
    chk("oe", 32'h3, {28'h0, pad_oe[3:0]});
    chk("out", 32'h0, {30'h0, pad_out[1:0]});
    @(posedge core_clk);
  endtask : t_out

  task automatic t_af();
    af_oe <= 16'h2000;
    af_out <= 16'h2000;
    ext <= 16'h200c;
    @(negedge core_clk);
    chk("af pp", 32'h3, {30'h0, pad_oe[13], pad_out[13]});
    @(posedge core_clk);
    wr(ad(`GPC_OFF_OTYPE), 32'h0000_2002);
    @(negedge core_clk);
    chk("af od", 32'h0, {31'h0, pad_oe[13]});
    @(posedge core_clk);
    rchk("istat", `GPC_OFF_ISTAT, 32'h0000_2008);
    af_out <= 16'h0;
    @(negedge core_clk);
    chk("af od", 32'h2, {30'h0, pad_oe[13], pad_out[13]});
    @(posedge core_clk);
    rchk("octl", `GPC_OFF_OCTL, 32'h0000_0004);
  endtask : t_af

  // pipelined toggles on pin 0, one per cycle
  task automatic t_tog();
    hsel <= 1'b1; haddr <= ad(`GPC_OFF_TG); htrans <= 2'h2; hwrite <= 1'b1;
    @(posedge core_clk);
    hwdata <= 32'h1;
    for (int k = 1; k <= 4; k++) begin
      @(posedge core_clk);
      if (k == 3) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
      end
      @(negedge core_clk);
      chk("toggle", {31'h0, k[0]}, {31'h0, pad_out[0]});
      chk("pin1", 32'h2, {30'h0, pad_oe[1], pad_out[1]});
    end
    @(posedge core_clk);
    wr(ad(`GPC_OFF_TG), 32'h0000_0003);
    rchk("octl", `GPC_OFF_OCTL, 32'h0000_0007);
    wr(ad(`GPC_OFF_BOP), 32'h0004_0008);
    wr(ad(`GPC_OFF_BC), 32'h0000_0001);
    rchk("octl", `GPC_OFF_OCTL, 32'h0000_000a);
  endtask : t_tog

  // speed, pull and alternate select fields reach their ports
  task automatic t_cfg();
    wr(ad(`GPC_OFF_SLEW), 32'h0000_00c1);
    wr(ad(`GPC_OFF_PULL), 32'h0000_0082);
    wr(ad(`GPC_OFF_AF0), 32'h0000_0056);
    wr(ad(`GPC_OFF_AF1), 32'h7000_0000);
    @(negedge core_clk);
    chk("slew", 32'h0000_00c1, slew_sel);
    chk("af lo", 32'h0000_0056, af_sel_lo);
    chk("af hi", 32'h7000_0000, af_sel_hi);
    chk("pulldn", 32'h0000_0009, {16'h0, pull_dn_en});
    chk("bus", 32'h2, {30'h0, hreadyout, hresp});
    @(posedge core_clk);
    rchk("af hi", `GPC_OFF_AF1, 32'h7000_0000);
  endtask : t_cfg

  task automatic t_lock();
    wr(ad(`GPC_OFF_LOCK), 32'h0001_0001);
    wr(ad(`GPC_OFF_LOCK), 32'h0000_0001);
    wr(ad(`GPC_OFF_LOCK), 32'h0001_0001);
    rchk("lock", `GPC_OFF_LOCK, 32'h0001_0001);
    wr(ad(`GPC_OFF_MODE), 32'h2800_0077);
    rchk("mode", `GPC_OFF_MODE, 32'h2800_0075);
    wr(ad(`GPC_OFF_OTYPE), 32'hffff_0001);
    rchk("otype", `GPC_OFF_OTYPE, 32'h0);
    wr(ad(`GPC_OFF_SLEW), 32'hffff_ffff);
    wr(ad(`GPC_OFF_PULL), 32'h0000_0000);
    wr(ad(`GPC_OFF_AF0), 32'h0000_0000);
    rchk("slew", `GPC_OFF_SLEW, 32'hffff_fffd);
    rchk("pull", `GPC_OFF_PULL, 32'h0000_0002);
    rchk("af lo", `GPC_OFF_AF0, 32'h0000_0006);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rchk("lock", `GPC_OFF_LOCK, 32'h0);
    rchk("mode", `GPC_OFF_MODE, 32'h2800_0000);
    rchk("slew", `GPC_OFF_SLEW, 32'h0);
    wr(ad(`GPC_OFF_MODE), 32'h2800_0003);
    rchk("mode", `GPC_OFF_MODE, 32'h2800_0003);
  endtask : t_lock

  task automatic t_map();
    logic [31:0] d;
    rchk("unmapped", 10'h030, 32'h0);
    rd(`GPC_BASE_B | {22'h0, `GPC_OFF_MODE}, d);
    chk("other base", 32'h0, d);
  endtask : t_map

  // ==================================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_out();
    t_af();
    t_tog();
    t_cfg();
    t_lock();
    t_map();
    summarize();
  end
endmodule : test_gpc_port
`default_nettype wire

// [include/gpc_cfg.svh]
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// ==================================================
// port base addresses
`define GPC_BASE_A 32'h4800_0000
`define GPC_BASE_B 32'h4800_0400
`define GPC_BASE_C 32'h4800_0800
`define GPC_BASE_F 32'h4800_1400
// ==================================================
// register offsets inside a port block
`define GPC_OFF_MODE 10'h000
`define GPC_OFF_OTYPE 10'h004
`define GPC_OFF_SLEW 10'h008
`define GPC_OFF_PULL 10'h00c
`define GPC_OFF_ISTAT 10'h010
`define GPC_OFF_OCTL 10'h014
`define GPC_OFF_BOP 10'h018
`define GPC_OFF_LOCK 10'h01c
`define GPC_OFF_AF0 10'h020
`define GPC_OFF_AF1 10'h024
`define GPC_OFF_BC 10'h028
`define GPC_OFF_TG 10'h02c
// ==================================================
// reset values
`define GPC_RST_MODE_A 32'h2800_0000
`define GPC_RST_MODE 32'h0000_0000
`define GPC_RST_OTYPE 16'h0000
`define GPC_RST_ZERO32 32'h0000_0000
`define GPC_RST_ZERO16 16'h0000
// ==================================================
// field positions and codes
`define GPC_LOCK_KEY_BIT 16
`define GPC_MODE_IN 2'h0
`define GPC_MODE_OUT 2'h1
`define GPC_MODE_AF 2'h2
`define GPC_MODE_AN 2'h3
`define GPC_PULL_UP 2'h1
`define GPC_PULL_DN 2'h2
`define GPC_PORT_A 2'h0
`define GPC_PORT_B 2'h1
`define GPC_PORT_C 2'h2
`endif

// [include/gpc_pkg.sv]
package gpc_pkg;
  // ==================================================
  // lock key sequence progress
  typedef enum logic [1:0] {
    GPC_LK_IDLE,
    GPC_LK_FIRST,
    GPC_LK_SECOND
  } gpc_lk_t;

  // ==================================================
  // whole state of the port
  typedef struct packed {
    logic [31:0] mode;
    logic [15:0] otype;
    logic [31:0] slew;
    logic [31:0] pull;
    logic [31:0] afsel0;
    logic [31:0] afsel1;
    logic [15:0] octl;
    logic [15:0] istat;
    logic [15:0] lock;
    logic lock_done;
    logic [15:0] lk_mask;
    gpc_lk_t lk_st;
    logic dp_valid;
    logic dp_write;
    logic [9:0] dp_off;
  } gpc_state_t;
endpackage : gpc_pkg

// [rtl/gpc_port.sv]
// Overview of operation
// - open-drain output drives low, else high-Z
// - push-pull output drives the control bit
// - output mode: buffer on if push-pull, Schmitt on, pulls
// - output register reads last written value
// - input status reads pad level in output
// - analog: no pulls, no buffer, no Schmitt
// - analog pins read zero in input status
// - alternate function: peripheral drives the buffer
// - alternate function samples pad every cycle
// - alternate open-drain reads real pad level
// - alternate push-pull also reads real pad level
// - lock register freezes per-pin configuration
// - locked pins ignore configuration writes until reset
// - toggle write inverts outputs in one cycle
// - back-to-back toggles give half-rate square
// - two mode bits per pin, four modes
// - port A mode resets 0x28000000, others zero
// - mode at 0x00, output type at 0x04
// - four port blocks at fixed bases
// - output type 0 push-pull, 1 open-drain
// - set/clear writes change only chosen bits
`timescale 1ns/100ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_port
  import gpc_pkg::*;
#(
  parameter logic [1:0] PORT_ID = 2'h0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] schmitt_en,
  output logic [15:0] pull_up_en,
  output logic [15:0] pull_dn_en,
  output logic [31:0] slew_sel,
  output logic [31:0] af_sel_lo,
  output logic [31:0] af_sel_hi,
  input wire logic [15:0] af_out,
  input wire logic [15:0] af_oe
);

  // ==================================================
  // helpers
  // widen a per-pin mask to the two-bit fields
  function automatic logic [31:0] gpc_expand2(input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      r[2*i] = m[i];
      r[2*i+1] = m[i];
    end
    return r;
  endfunction : gpc_expand2

  // pins whose mode field holds a given code
  function automatic logic [15:0] gpc_mode_is(input logic [31:0] md, input logic [1:0] code);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = (md[2*i +: 2] == code);
    end
    return r;
  endfunction : gpc_mode_is

  // keep locked fields, take written ones elsewhere
  function automatic logic [31:0] gpc_guard(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] lk);
    return (old & lk) | (wd & ~lk);
  endfunction : gpc_guard

  // ==================================================
  // constants picked by port
  localparam logic [31:0] BASE = (PORT_ID == `GPC_PORT_A) ? `GPC_BASE_A :
                                 (PORT_ID == `GPC_PORT_B) ? `GPC_BASE_B :
                                 (PORT_ID == `GPC_PORT_C) ? `GPC_BASE_C : `GPC_BASE_F;
  localparam logic [31:0] MODE_RST = (PORT_ID == `GPC_PORT_A) ? `GPC_RST_MODE_A : `GPC_RST_MODE;

  gpc_state_t st;
  gpc_state_t next_st;
  logic [31:0] lk2;
  logic [15:0] is_out;
  logic [15:0] is_af;
  logic [15:0] is_an;
  logic addr_hit;
  logic [15:0] wd16;
  logic dp_wr;
  logic [15:0] wd_hi;
  logic [31:0] otype_guard;

  // ==================================================
  // decode of the current state
  assign lk2 = gpc_expand2(st.lock);
  assign is_out = gpc_mode_is(st.mode, `GPC_MODE_OUT);
  assign is_af = gpc_mode_is(st.mode, `GPC_MODE_AF);
  assign is_an = gpc_mode_is(st.mode, `GPC_MODE_AN);
  assign addr_hit = hsel && htrans[1] && hready && (haddr[31:10] == BASE[31:10]);
  assign wd16 = hwdata[15:0];
  // upper write half, the clear mask of a set/clear write
  assign wd_hi = hwdata[31:16];
  // output type is only 16 wide, guard it on a zero-padded word
  assign otype_guard = gpc_guard({16'h0000, st.otype}, {16'h0000, wd16}, {16'h0000, st.lock});
  assign dp_wr = st.dp_valid && st.dp_write;

  // ==================================================
  // next state
  always_comb begin
    next_st = st;
    // address phase capture
    next_st.dp_valid = addr_hit;
    next_st.dp_write = hwrite;
    next_st.dp_off = haddr[9:0];
    // pad sampling each cycle, analog pins forced low
    next_st.istat = pad_in & ~is_an;
    if (dp_wr) begin
      case (st.dp_off)
        `GPC_OFF_MODE: next_st.mode = gpc_guard(st.mode, hwdata, lk2);
        `GPC_OFF_OTYPE: next_st.otype = otype_guard[15:0];
        `GPC_OFF_SLEW: next_st.slew = gpc_guard(st.slew, hwdata, lk2);
        `GPC_OFF_PULL: next_st.pull = gpc_guard(st.pull, hwdata, lk2);
        `GPC_OFF_AF0: next_st.afsel0 = gpc_guard(st.afsel0, hwdata,
                                                 {{4{st.lock[7]}}, {4{st.lock[6]}}, {4{st.lock[5]}},
                                                  {4{st.lock[4]}}, {4{st.lock[3]}}, {4{st.lock[2]}},
                                                  {4{st.lock[1]}}, {4{st.lock[0]}}});
        `GPC_OFF_AF1: next_st.afsel1 = gpc_guard(st.afsel1, hwdata,
                                                 {{4{st.lock[15]}}, {4{st.lock[14]}}, {4{st.lock[13]}},
                                                  {4{st.lock[12]}}, {4{st.lock[11]}}, {4{st.lock[10]}},
                                                  {4{st.lock[9]}}, {4{st.lock[8]}}});
        `GPC_OFF_OCTL: next_st.octl = wd16;
        // set in low half wins over clear in high half
        `GPC_OFF_BOP: next_st.octl = (st.octl & ~wd_hi) | wd16;
        `GPC_OFF_BC: next_st.octl = st.octl & ~wd16;
        `GPC_OFF_TG: next_st.octl = st.octl ^ wd16;
        `GPC_OFF_LOCK: begin
          // key written 1, 0, 1 with the same mask commits
          case (st.lk_st)
            GPC_LK_IDLE: begin
              next_st.lk_mask = wd16;
              next_st.lk_st = hwdata[`GPC_LOCK_KEY_BIT] ? GPC_LK_FIRST : GPC_LK_IDLE;
            end
            GPC_LK_FIRST: begin
              next_st.lk_st = (!hwdata[`GPC_LOCK_KEY_BIT] && wd16 == st.lk_mask) ?
                              GPC_LK_SECOND : GPC_LK_IDLE;
            end
            GPC_LK_SECOND: begin
              next_st.lk_st = GPC_LK_IDLE;
              if (hwdata[`GPC_LOCK_KEY_BIT] && wd16 == st.lk_mask && !st.lock_done) begin
                next_st.lock = st.lk_mask;
                next_st.lock_done = 1'b1;
              end
            end
            default: next_st.lk_st = GPC_LK_IDLE;
          endcase
        end
        default: next_st.octl = st.octl;
      endcase
    end
    // lock stays until reset
    if (srst) begin
      next_st.mode = MODE_RST;
      next_st.otype = `GPC_RST_OTYPE;
      next_st.slew = `GPC_RST_ZERO32;
      next_st.pull = `GPC_RST_ZERO32;
      next_st.afsel0 = `GPC_RST_ZERO32;
      next_st.afsel1 = `GPC_RST_ZERO32;
      next_st.octl = `GPC_RST_ZERO16;
      next_st.istat = `GPC_RST_ZERO16;
      next_st.lock = `GPC_RST_ZERO16;
      next_st.lock_done = 1'b0;
      next_st.lk_mask = `GPC_RST_ZERO16;
      next_st.lk_st = GPC_LK_IDLE;
      next_st.dp_valid = 1'b0;
      next_st.dp_write = 1'b0;
      next_st.dp_off = 10'h000;
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // ==================================================
  // bus answer: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // read mux, unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (st.dp_valid && !st.dp_write) begin
      case (st.dp_off)
        `GPC_OFF_MODE: hrdata = st.mode;
        `GPC_OFF_OTYPE: hrdata = {16'h0000, st.otype};
        `GPC_OFF_SLEW: hrdata = st.slew;
        `GPC_OFF_PULL: hrdata = st.pull;
        `GPC_OFF_ISTAT: hrdata = {16'h0000, st.istat};
        `GPC_OFF_OCTL: hrdata = {16'h0000, st.octl};
        `GPC_OFF_LOCK: hrdata = {15'h0000, st.lock_done, st.lock};
        `GPC_OFF_AF0: hrdata = st.afsel0;
        `GPC_OFF_AF1: hrdata = st.afsel1;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==================================================
  // pad control per pin
  always_comb begin
    pad_out = 16'h0000;
    pad_oe = 16'h0000;
    schmitt_en = 16'h0000;
    pull_up_en = 16'h0000;
    pull_dn_en = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      schmitt_en[i] = !is_an[i];
      pull_up_en[i] = !is_an[i] && (st.pull[2*i +: 2] == `GPC_PULL_UP);
      pull_dn_en[i] = !is_an[i] && (st.pull[2*i +: 2] == `GPC_PULL_DN);
      if (is_out[i]) begin
        // open-drain only ever pulls low
        pad_out[i] = st.otype[i] ? 1'b0 : st.octl[i];
        pad_oe[i] = st.otype[i] ? !st.octl[i] : 1'b1;
      end else if (is_af[i]) begin
        pad_out[i] = st.otype[i] ? 1'b0 : af_out[i];
        pad_oe[i] = af_oe[i] && (st.otype[i] ? !af_out[i] : 1'b1);
      end
    end
  end

  assign slew_sel = st.slew;
  assign af_sel_lo = st.afsel0;
  assign af_sel_hi = st.afsel1;

  // ==================================================
  // checks
  AST_OD_RELEASE: assert property (@(posedge core_clk) disable iff (srst)
    ((is_out & st.otype & ((pad_oe ^ ~st.octl) | pad_out)) == 16'h0000))
    else $error("open-drain output drive wrong");
  AST_PP_DRIVE: assert property (@(posedge core_clk) disable iff (srst)
    ((is_out & ~st.otype & (~pad_oe | (pad_out ^ st.octl))) == 16'h0000))
    else $error("push-pull output drive wrong");
  AST_OUT_BUF_ON: assert property (@(posedge core_clk) disable iff (srst)
    ((is_out & ((~st.otype & ~pad_oe) | ~schmitt_en)) == 16'h0000))
    else $error("output pin lost buffer or trigger");
  AST_OUT_PULL_SEL: assert property (@(posedge core_clk) disable iff (srst)
    (is_out[0] && st.pull[1:0] == `GPC_PULL_UP) |-> pull_up_en[0])
    else $error("output pin pull-up not selectable");
  AST_INPUT_NO_DRIVE: assert property (@(posedge core_clk) disable iff (srst)
    ((pad_oe & ~is_out & ~is_af) == 16'h0000))
    else $error("input or analog pin driven");
  AST_ANALOG_OFF: assert property (@(posedge core_clk) disable iff (srst)
    ((is_an & (pad_oe | schmitt_en | pull_up_en | pull_dn_en)) == 16'h0000))
    else $error("analog pin still has buffer, pull or trigger");
  AST_ANALOG_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    ##1 ((st.istat & $past(is_an)) == 16'h0000))
    else $error("analog pin reads nonzero status");
  AST_AF_DRIVE: assert property (@(posedge core_clk) disable iff (srst)
    ((is_af & ~st.otype & af_oe & (~pad_oe | (pad_out ^ af_out))) == 16'h0000))
    else $error("alternate push-pull not driven by peripheral");
  AST_AF_OD: assert property (@(posedge core_clk) disable iff (srst)
    ((is_af & st.otype & (pad_out | (pad_oe ^ (af_oe & ~af_out)))) == 16'h0000))
    else $error("alternate open-drain drive wrong");
  AST_AF_SCHMITT: assert property (@(posedge core_clk) disable iff (srst)
    ((is_af & ~schmitt_en) == 16'h0000))
    else $error("alternate pin trigger off");

  // ==================================================
  // register checks
  AST_SAMPLE_PAD: assert property (@(posedge core_clk) disable iff (srst)
    !srst |=> (((st.istat ^ $past(pad_in)) & ($past(is_out) | $past(is_af))) == 16'h0000))
    else $error("pad level not sampled");
  AST_READ_ISTAT: assert property (@(posedge core_clk) disable iff (srst)
    (st.dp_valid && !st.dp_write && st.dp_off == `GPC_OFF_ISTAT) |-> (hrdata == {16'h0000, st.istat}))
    else $error("input status read wrong");
  AST_OCTL_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_OCTL) |=> (st.octl == $past(wd16)))
    else $error("output level write lost");
  AST_READ_OCTL: assert property (@(posedge core_clk) disable iff (srst)
    (st.dp_valid && !st.dp_write && st.dp_off == `GPC_OFF_OCTL) |-> (hrdata == {16'h0000, st.octl}))
    else $error("output level read wrong");
  AST_OTYPE_READ: assert property (@(posedge core_clk) disable iff (srst)
    (st.dp_valid && !st.dp_write && st.dp_off == `GPC_OFF_OTYPE) |-> (hrdata == {16'h0000, st.otype}))
    else $error("output type read wrong");
  AST_MODE_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_MODE && st.lock == 16'h0000) |=> (st.mode == $past(hwdata)))
    else $error("mode write lost");
  AST_ADDR_DECODE: assert property (@(posedge core_clk) disable iff (srst)
    (hsel && htrans[1] && hready && haddr[31:10] != BASE[31:10]) |=> !st.dp_valid)
    else $error("foreign address taken");
  AST_BUS_ANSWER: assert property (@(posedge core_clk) disable iff (srst)
    (hreadyout && !hresp))
    else $error("bus answer not zero-wait okay");
  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_TG) |=> (st.octl == ($past(st.octl) ^ $past(wd16))))
    else $error("toggle write gave wrong output");
  AST_BOP: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_BOP) |=> (st.octl == (($past(st.octl) & ~$past(wd_hi)) | $past(wd16))))
    else $error("set/clear write gave wrong output");
  AST_BC: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_BC) |=> (st.octl == ($past(st.octl) & ~$past(wd16))))
    else $error("clear write gave wrong output");

  // ==================================================
  // lock checks
  AST_LOCK_READ: assert property (@(posedge core_clk) disable iff (srst)
    (st.dp_valid && !st.dp_write && st.dp_off == `GPC_OFF_LOCK) |-> (hrdata[16:0] == {st.lock_done, st.lock}))
    else $error("lock read wrong");
  AST_LOCK_COMMIT: assert property (@(posedge core_clk) disable iff (srst)
    (!srst && dp_wr && st.dp_off == `GPC_OFF_LOCK && st.lk_st == GPC_LK_SECOND && hwdata[`GPC_LOCK_KEY_BIT]
     && wd16 == st.lk_mask && !st.lock_done) |=> (st.lock_done && st.lock == $past(st.lk_mask)))
    else $error("lock key sequence did not commit");
  AST_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !srst |=> ((st.mode & $past(lk2)) == ($past(st.mode) & $past(lk2))))
    else $error("locked mode field changed");
  AST_LOCK_OTYPE: assert property (@(posedge core_clk) disable iff (srst)
    !srst |=> ((st.otype & $past(st.lock)) == ($past(st.otype) & $past(st.lock))))
    else $error("locked output type changed");
  AST_LOCK_FIELDS: assert property (@(posedge core_clk) disable iff (srst)
    !srst |=> ((((st.slew ^ $past(st.slew)) | (st.pull ^ $past(st.pull))) & $past(lk2)) == 32'h0000_0000))
    else $error("locked speed or pull field changed");
  AST_LOCK_STICKY: assert property (@(posedge core_clk) disable iff (srst)
    (st.lock_done && !srst) |=> (st.lock_done && $stable(st.lock)))
    else $error("lock released before reset");
  AST_MODE_RESET: assert property (@(posedge core_clk) disable iff (srst)
    $past(srst) |-> (st.mode == MODE_RST && st.otype == 16'h0000))
    else $error("mode or output type reset value wrong");

endmodule : gpc_port
`default_nettype wire
